//--- design/imm_pkg.sv
// Constants, field positions and types for the memory interleave mapper.
// Assumes a 40-bit coherent physical address with bit 39 as the line-byte end.
package imm_pkg;

  typedef enum logic [2:0] {
    mode_single,
    mode_one_pair,
    mode_two_pair,
    mode_three_pair,
    mode_four_pair
  } imm_mode_t;

  localparam int ADDR_W = 40;
  localparam int DATA_W = 32;
  localparam int RADDR_W = 4;

  // Address fields, counted from the low end of the address vector
  localparam int ROW_LSB = 31;
  localparam int BLK_SEL_LSB = 28;
  localparam int BANK_SEL_LSB = 26;
  localparam int SUB_W = 26;
  localparam int SMALL_LSB = 24;
  localparam int LINE_W = 5;
  localparam int PAGE_BYTES = 4096;
  localparam int PAGE_LINES = PAGE_BYTES / (1 << LINE_W);

  // Rotate index bit positions per mode
  localparam int BANK_ROT_NONE_LSB = 5;
  localparam int BANK_ROT_ONE_LSB = 6;
  localparam int BLK_ROT_ONE_LSB = 5;
  localparam int BANK_ROT_TWO_LSB = 7;
  localparam int BLK_ROT_TWO_LSB = 5;
  localparam int BANK_ROT_FOUR_LSB = 8;
  localparam int BLK_ROT_FOUR_LSB = 5;

  // Register word addresses
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_BOARD_MAP = 4'h1;
  localparam logic [3:0] REG_ONLINE = 4'h2;
  localparam logic [3:0] REG_SMALL_ROW = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FAULT_INFO = 4'h5;

  // Field positions inside registers
  localparam int CFG_TWO_BANK_BIT = 3;
  localparam int ST_SEEN_BIT = 0;
  localparam int ST_RANGE_BIT = 1;
  localparam int ST_COUNT_LSB = 8;

  // Reset values
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [23:0] RST_BOARD_MAP = 24'hfac688;
  localparam logic [7:0] RST_ONLINE = 8'h00;
  localparam logic [7:0] RST_SMALL_ROW = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

endpackage : imm_pkg

//--- design/imm_idx_if.sv
// Carrier between the mapper top and its two index and block stages.
// Assumes purely combinational use inside one clock domain.
interface imm_idx_if;
  imm_pkg::imm_mode_t mode;
  logic [imm_pkg::ADDR_W-1:0] addr;
  logic two_bank;
  logic [1:0] bank_idx;
  logic [2:0] block_idx;
  logic [2:0] logical_block;
  logic [1:0] bank;

  modport sel (input mode, input addr, output bank_idx, output block_idx);
  modport calc (input mode, input addr, input two_bank, input bank_idx, input block_idx,
                output logical_block, output bank);
  modport top (output mode, output addr, output two_bank, input logical_block, input bank);
endinterface : imm_idx_if

//--- design/imm_rotate_sel.sv
// Picks the bank and block rotate indices from the line position in the page.
// Assumes mode holds a legal code.
module imm_rotate_sel (
  imm_idx_if.sel idx
);

  always_comb begin
    idx.bank_idx = idx.addr[imm_pkg::BANK_ROT_NONE_LSB +: 2];
    idx.block_idx = 3'h0;
    unique case (idx.mode)
      imm_pkg::mode_single: begin
        idx.bank_idx = idx.addr[imm_pkg::BANK_ROT_NONE_LSB +: 2]; // [R6]
        idx.block_idx = 3'h0; // [R6]
      end
      imm_pkg::mode_one_pair: begin
        idx.bank_idx = idx.addr[imm_pkg::BANK_ROT_ONE_LSB +: 2]; // [R7]
        idx.block_idx = {2'h0, idx.addr[imm_pkg::BLK_ROT_ONE_LSB]}; // [R7]
      end
      imm_pkg::mode_two_pair, imm_pkg::mode_three_pair: begin
        idx.bank_idx = idx.addr[imm_pkg::BANK_ROT_TWO_LSB +: 2]; // [R7]
        idx.block_idx = {1'b0, idx.addr[imm_pkg::BLK_ROT_TWO_LSB +: 2]}; // [R7]
      end
      imm_pkg::mode_four_pair: begin
        idx.bank_idx = idx.addr[imm_pkg::BANK_ROT_FOUR_LSB +: 2]; // [R7]
        idx.block_idx = idx.addr[imm_pkg::BLK_ROT_FOUR_LSB +: 3]; // [R7]
      end
    endcase
  end

endmodule // imm_rotate_sel

//--- design/imm_block_bank.sv
// Rotates the block and bank select fields by the rotate indices.
// Assumes mode holds a legal code.
module imm_block_bank (
  imm_idx_if.calc idx
);

  logic [2:0] blk_sel;
  logic [1:0] bank_sel;

  assign blk_sel = idx.addr[imm_pkg::BLK_SEL_LSB +: 3];
  assign bank_sel = idx.addr[imm_pkg::BANK_SEL_LSB +: 2];

  always_comb begin
    idx.logical_block = blk_sel;
    unique case (idx.mode)
      imm_pkg::mode_single: idx.logical_block = blk_sel; // [R8] [R14]
      imm_pkg::mode_one_pair: idx.logical_block = {blk_sel[2:1], blk_sel[0] ^ idx.block_idx[0]}; // [R9]
      imm_pkg::mode_two_pair, imm_pkg::mode_three_pair: begin
        idx.logical_block = {blk_sel[2], 2'(blk_sel[1:0] + idx.block_idx[1:0])}; // [R10] [R2]
      end
      imm_pkg::mode_four_pair: idx.logical_block = 3'(blk_sel + idx.block_idx); // [R11]
    endcase
  end

  // Two-bank controllers only honour the low bank bit
  always_comb begin
    if (idx.two_bank) begin
      idx.bank = {1'b0, bank_sel[0] ^ idx.bank_idx[0]}; // [R20] [R13]
    end else begin
      idx.bank = 2'(bank_sel + idx.bank_idx); // [R12] [R13]
    end
  end

endmodule // imm_block_bank

//--- design/imm_mapper.sv
// Top of the memory interleave mapper: register file, online and range checks, output stage.
// Assumes requests are coherent memory references and configuration is quiet while they flow.
// Behaviour
// [R1] Support single block, one pair, two pairs and four pairs interleave spans.
// [R2] Three installed pairs use the same sixteen-way mode as two pairs.
// [R3] Block interleave applies to every coherent reference except in single-block mode.
// [R4] Logical block is translated to a physical board through a programmed map.
// [R5] Offline logical block raises fatal machine check instead of issuing the access; the code tests the online bit of the unrotated block select.
// [R6] Without interleave block index is zero, bank index from bits 33:34.
// [R7] Rotate index bits chosen from page offset according to the pair count.
// [R8] Noninterleaved logical block equals the block select field unchanged.
// [R9] One pair: invert block select low bit when the rotate index is one.
// [R10] Two pairs: keep top block bit, add rotate index to low two, mod four.
// [R11] Four pairs: block select plus three-bit rotate index, modulo eight.
// [R12] Bank equals bank select plus bank rotate index, mod four, with four banks.
// [R13] Controllers may be configured with two or four banks.
// [R14] Single-block mode keeps lines in one block, rotating over its banks.
// [R15] Two blocks give eight-way, four or six blocks give sixteen-way interleave.
// [R16] Small-density rows expose only the first 16 Mbytes of each subpartition.
// [R17] Patterns repeat over 4096-byte pages of 128 lines.
// [R18] Block select field is three bits choosing one of eight boards.
// [R19] Bank select field is two bits choosing one of four banks.
// [R20] Two-bank controllers sum only low bits of select and index, modulo two.
// [R21] Mode, pair count and bank count are held stable configuration.
//
// Our own choices: the register addresses and the address-and-strobe port.
module imm_mapper (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [imm_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [imm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [imm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [imm_pkg::ADDR_W-1:0] req_addr,
  output logic resp_valid,
  output logic [2:0] resp_board,
  output logic [1:0] resp_bank,
  output logic [2:0] resp_row,
  output logic [imm_pkg::SUB_W-1:0] resp_offset,
  output logic fatal_machine_check
);

  imm_pkg::imm_mode_t mode_q;
  logic two_bank_q;
  logic [23:0] board_map_q;
  logic [7:0] online_q;
  logic [7:0] small_row_q;
  logic seen_q;
  logic range_q;
  logic [7:0] count_q;
  logic [2:0] fault_block_q;
  logic [2:0] fault_row_q;
  logic [2:0] lb_q;
  logic [imm_pkg::DATA_W-1:0] rdata_d;
  logic [2:0] blk_sel;
  logic [2:0] row;
  logic [2:0] board_d;
  logic offline;
  logic out_of_range;
  logic fault_d;
  logic st_clear;

  imm_idx_if idx ();

  // Configuration reaches the stages unregistered; it must stay quiet during traffic
  assign idx.mode = mode_q; // [R21]
  assign idx.addr = req_addr;
  assign idx.two_bank = two_bank_q;

  imm_rotate_sel u_sel (
    .idx (idx)
  );

  imm_block_bank u_calc (
    .idx (idx)
  );

  assign blk_sel = req_addr[imm_pkg::BLK_SEL_LSB +: 3]; // [R18]
  assign row = req_addr[imm_pkg::ROW_LSB +: 3];
  assign board_d = board_map_q[3*idx.logical_block +: 3]; // [R4]
  assign offline = !online_q[blk_sel]; // [R5]
  assign out_of_range = small_row_q[row] && (req_addr[imm_pkg::SMALL_LSB +: 2] != 2'h0); // [R16]
  assign fault_d = req_valid && (offline || out_of_range);
  assign st_clear = reg_wr && (reg_addr == imm_pkg::REG_STATUS) && reg_wdata[imm_pkg::ST_SEEN_BIT];

  // Configuration register; illegal mode codes fall back to single block
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= imm_pkg::imm_mode_t'(imm_pkg::RST_MODE);
      two_bank_q <= 1'b0;
    end else if (reg_wr && reg_addr == imm_pkg::REG_CONFIG) begin
      if (reg_wdata[2:0] > 3'(imm_pkg::mode_four_pair)) begin
        mode_q <= imm_pkg::mode_single;
      end else begin
        mode_q <= imm_pkg::imm_mode_t'(reg_wdata[2:0]); // [R1]
      end
      two_bank_q <= reg_wdata[imm_pkg::CFG_TWO_BANK_BIT]; // [R13]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      board_map_q <= imm_pkg::RST_BOARD_MAP;
    end else if (reg_wr && reg_addr == imm_pkg::REG_BOARD_MAP) begin
      board_map_q <= reg_wdata[23:0]; // [R4]
    end
  end

  // Online mask starts cleared so software must bring boards up first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      online_q <= imm_pkg::RST_ONLINE;
    end else if (reg_wr && reg_addr == imm_pkg::REG_ONLINE) begin
      online_q <= reg_wdata[7:0]; // [R5]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      small_row_q <= imm_pkg::RST_SMALL_ROW;
    end else if (reg_wr && reg_addr == imm_pkg::REG_SMALL_ROW) begin
      small_row_q <= reg_wdata[7:0]; // [R16]
    end
  end

  // Sticky fault status; a new fault beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
      range_q <= 1'b0;
      count_q <= imm_pkg::RST_COUNT;
      fault_block_q <= 3'h0;
      fault_row_q <= 3'h0;
    end else begin
      if (fault_d) begin
        seen_q <= 1'b1;
        range_q <= !offline && out_of_range;
        fault_block_q <= blk_sel;
        fault_row_q <= row;
        if (count_q != 8'hff) begin
          count_q <= 8'(count_q + 8'h01);
        end
      end else if (st_clear) begin
        seen_q <= 1'b0;
        range_q <= 1'b0;
        count_q <= imm_pkg::RST_COUNT;
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      imm_pkg::REG_CONFIG: begin
        rdata_d[2:0] = 3'(mode_q);
        rdata_d[imm_pkg::CFG_TWO_BANK_BIT] = two_bank_q;
      end
      imm_pkg::REG_BOARD_MAP: rdata_d[23:0] = board_map_q;
      imm_pkg::REG_ONLINE: rdata_d[7:0] = online_q;
      imm_pkg::REG_SMALL_ROW: rdata_d[7:0] = small_row_q;
      imm_pkg::REG_STATUS: begin
        rdata_d[imm_pkg::ST_SEEN_BIT] = seen_q;
        rdata_d[imm_pkg::ST_RANGE_BIT] = range_q;
        rdata_d[imm_pkg::ST_COUNT_LSB +: 8] = count_q;
      end
      imm_pkg::REG_FAULT_INFO: rdata_d[5:0] = {fault_row_q, fault_block_q};
      default: rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Output stage: one cycle of latency, faulted accesses are never issued
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      fatal_machine_check <= 1'b0;
    end else begin
      resp_valid <= req_valid && !fault_d; // [R5] [R3]
      fatal_machine_check <= fault_d; // [R5] [R16]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resp_board <= 3'h0;
      resp_bank <= 2'h0;
      resp_row <= 3'h0;
      resp_offset <= '0;
      lb_q <= 3'h0;
    end else if (req_valid) begin
      resp_board <= board_d; // [R4] [R15]
      resp_bank <= idx.bank; // [R12] [R19]
      resp_row <= row;
      resp_offset <= req_addr[imm_pkg::SUB_W-1:0]; // [R17]
      lb_q <= idx.logical_block;
    end
  end

  // Checks

  a_issue_or_fault: assert property (@(posedge clock) disable iff (sys_rst) // [R5]
    req_valid |=> (resp_valid ^ fatal_machine_check))
    else $error("request produced neither access nor fault");

  a_offline_fault: assert property (@(posedge clock) disable iff (sys_rst) // [R5]
    req_valid && !online_q[blk_sel] |=> fatal_machine_check && !resp_valid)
    else $error("offline block access was issued");

  a_fault_sticky: assert property (@(posedge clock) disable iff (sys_rst) // [R5]
    fault_d |=> seen_q && fatal_machine_check)
    else $error("fault did not set the sticky status");

  // A clear in the same cycle must not stop the count from stepping
  a_fault_count: assert property (@(posedge clock) disable iff (sys_rst) // [R5]
    fault_d && count_q != 8'hff |=> count_q == 8'($past(count_q) + 8'h01))
    else $error("fault count did not step");

  a_board_map: assert property (@(posedge clock) disable iff (sys_rst) // [R4]
    resp_valid |-> resp_board == board_map_q[3*lb_q +: 3])
    else $error("board does not follow the map");

  a_data_hold: assert property (@(posedge clock) disable iff (sys_rst) // [R4]
    !$past(req_valid) |-> $stable(resp_board) && $stable(resp_bank))
    else $error("response fields moved without a request");

  a_single_block: assert property (@(posedge clock) disable iff (sys_rst) // [R8] [R3]
    req_valid && mode_q == imm_pkg::mode_single |=> lb_q == $past(blk_sel))
    else $error("single block mode rotated the block");

  a_one_pair_flip: assert property (@(posedge clock) disable iff (sys_rst) // [R9]
    req_valid && mode_q == imm_pkg::mode_one_pair
    |=> lb_q == $past({blk_sel[2:1], blk_sel[0] ^ req_addr[imm_pkg::BLK_ROT_ONE_LSB]}))
    else $error("one pair block wrong");

  a_two_pair_sum: assert property (@(posedge clock) disable iff (sys_rst) // [R10] [R2]
    req_valid && (mode_q == imm_pkg::mode_two_pair || mode_q == imm_pkg::mode_three_pair)
    |=> lb_q == $past({blk_sel[2], 2'(blk_sel[1:0] + req_addr[imm_pkg::BLK_ROT_TWO_LSB +: 2])}))
    else $error("two pair block wrong");

  a_four_pair_sum: assert property (@(posedge clock) disable iff (sys_rst) // [R11]
    req_valid && mode_q == imm_pkg::mode_four_pair
    |=> lb_q == $past(3'(blk_sel + req_addr[imm_pkg::BLK_ROT_FOUR_LSB +: 3])))
    else $error("four pair block wrong");

  a_single_bank: assert property (@(posedge clock) disable iff (sys_rst) // [R6] [R12]
    req_valid && mode_q == imm_pkg::mode_single && !two_bank_q
    |=> resp_bank == $past(2'(req_addr[imm_pkg::BANK_SEL_LSB +: 2] + req_addr[imm_pkg::BANK_ROT_NONE_LSB +: 2])))
    else $error("single block bank rotation wrong");

  a_one_pair_bank: assert property (@(posedge clock) disable iff (sys_rst) // [R7] [R12]
    req_valid && mode_q == imm_pkg::mode_one_pair && !two_bank_q
    |=> resp_bank == $past(2'(req_addr[imm_pkg::BANK_SEL_LSB +: 2] + req_addr[imm_pkg::BANK_ROT_ONE_LSB +: 2])))
    else $error("one pair bank rotation wrong");

  a_two_pair_bank: assert property (@(posedge clock) disable iff (sys_rst) // [R7] [R12] [R2]
    req_valid && (mode_q == imm_pkg::mode_two_pair || mode_q == imm_pkg::mode_three_pair) && !two_bank_q
    |=> resp_bank == $past(2'(req_addr[imm_pkg::BANK_SEL_LSB +: 2] + req_addr[imm_pkg::BANK_ROT_TWO_LSB +: 2])))
    else $error("two pair bank rotation wrong");

  a_four_pair_bank: assert property (@(posedge clock) disable iff (sys_rst) // [R7] [R12]
    req_valid && mode_q == imm_pkg::mode_four_pair && !two_bank_q
    |=> resp_bank == $past(2'(req_addr[imm_pkg::BANK_SEL_LSB +: 2] + req_addr[imm_pkg::BANK_ROT_FOUR_LSB +: 2])))
    else $error("four pair bank rotation wrong");

  a_two_bank_low: assert property (@(posedge clock) disable iff (sys_rst) // [R20]
    req_valid && two_bank_q |=> resp_bank[1] == 1'b0)
    else $error("two bank mode used the upper bank");

  a_two_bank_sum: assert property (@(posedge clock) disable iff (sys_rst) // [R20] [R6]
    req_valid && mode_q == imm_pkg::mode_single && two_bank_q
    |=> resp_bank[0] == $past(req_addr[imm_pkg::BANK_SEL_LSB] ^ req_addr[imm_pkg::BANK_ROT_NONE_LSB]))
    else $error("two bank rotation wrong");

  a_small_range: assert property (@(posedge clock) disable iff (sys_rst) // [R16]
    req_valid && out_of_range |=> fatal_machine_check && seen_q)
    else $error("small row overrun not faulted");

  a_range_flag: assert property (@(posedge clock) disable iff (sys_rst) // [R16]
    req_valid && out_of_range && online_q[blk_sel] |=> range_q)
    else $error("range only fault not flagged");

  a_rdata_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");

  c_small_overrun: cover property (@(posedge clock) disable iff (sys_rst)
    req_valid && out_of_range ##1 fatal_machine_check);

  c_four_pair: cover property (@(posedge clock) disable iff (sys_rst)
    req_valid && mode_q == imm_pkg::mode_four_pair ##1 resp_valid);
  c_offline: cover property (@(posedge clock) disable iff (sys_rst)
    req_valid && offline ##1 fatal_machine_check);
  c_two_bank: cover property (@(posedge clock) disable iff (sys_rst)
    req_valid && two_bank_q ##1 resp_valid);
  c_clear_race: cover property (@(posedge clock) disable iff (sys_rst)
    fault_d && st_clear);

endmodule // imm_mapper

//--- test/imm_agent.sv
// Processor agent model that issues coherent memory requests to the mapper.
// Assumes one clock domain; the bench calls send() from its scenarios.
module imm_agent (
  input wire logic clock,
  output logic req_valid,
  output logic [imm_pkg::ADDR_W-1:0] req_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'b0;
    req_addr = '0;
  end
  // Idle address is inverted so a stale value never looks like a live request
  task automatic send(input logic [imm_pkg::ADDR_W-1:0] a);
    @(posedge clock);
    req_valid <= 1'b1;
    req_addr <= a;
    @(posedge clock);
    req_valid <= 1'b0;
    req_addr <= ~a;
  endtask
endmodule // imm_agent

//--- test/imm_mapper_test.sv
// Self-checking bench for the memory interleave mapper.
// Assumes one-cycle register reads and responses one cycle after each request.
module imm_mapper_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic req_valid;
  logic [39:0] req_addr;
  logic resp_valid;
  logic [2:0] resp_board;
  logic [1:0] resp_bank;
  logic [2:0] resp_row;
  logic [25:0] resp_offset;
  logic fatal_machine_check;
  int errors = 0;
  int checked = 0;

  always #20 clock = ~clock;

  imm_agent agent (.clock(clock), .req_valid(req_valid), .req_addr(req_addr));
  imm_mapper uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_addr(req_addr), .resp_valid(resp_valid), .resp_board(resp_board), .resp_bank(resp_bank),
    .resp_row(resp_row), .resp_offset(resp_offset), .fatal_machine_check(fatal_machine_check));

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic req(input logic [39:0] a, input logic ok, input logic [2:0] brd, input logic [1:0] bnk);
    agent.send(a);
    #1;
    chk({resp_valid, fatal_machine_check}, {ok, ~ok});
    if (ok) begin
      chk({resp_board, resp_bank}, {brd, bnk});
      chk({resp_row, resp_offset}, {a[33:31], a[25:0]});
    end
  endtask

  // Block and bank worked out independently per interleave mode
  function automatic logic [4:0] expect_map(input int m, input logic tb, input logic [39:0] a);
    logic [2:0] sel;
    logic [1:0] bsel;
    logic [2:0] blk;
    logic [1:0] rot;
    sel = a[30:28];
    bsel = a[27:26];
    case (m)
      1: blk = {sel[2:1], sel[0] ^ a[5]};
      2, 3: blk = {sel[2], 2'(sel[1:0] + a[6:5])};
      4: blk = 3'(sel + a[7:5]);
      default: blk = sel;
    endcase
    rot = (m == 0) ? a[6:5] : (m == 1) ? a[7:6] : (m < 4) ? a[8:7] : a[9:8];
    return {3'(7 - blk), tb ? {1'b0, bsel[0] ^ rot[0]} : 2'(bsel + rot)};
  endfunction

  task automatic test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reset_state;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h00fac688);
    rd(4'h2, 32'h0);
    wr(4'h6, 32'hffffffff);
    rd(4'h6, 32'h0);
    wr(4'h0, 32'h5);
    rd(4'h0, 32'h0);
    req(40'h0010000000, 1'b0, 3'h0, 2'h0);
  endtask

  // Every mode and bank count, board map reversed so the translation shows
  task automatic mode_sweep;
    logic [39:0] a;
    logic [4:0] e;
    logic [23:0] mapv;
    for (int i = 0; i < 8; i++) begin
      mapv[3*i +: 3] = 3'(7 - i);
    end
    wr(4'h1, {8'h0, mapv});
    wr(4'h2, 32'hff);
    for (int m = 0; m < 5; m++) begin
      for (int tb = 0; tb < 2; tb++) begin
        wr(4'h0, 32'(tb * 8 + m));
        for (int k = 0; k < 24; k++) begin
          a = '0;
          a[30:28] = 3'(k);
          a[27:26] = 2'(k / 8 + k);
          a[9:5] = 5'(k * 7);
          a[33:31] = 3'(k + 1);
          a[20:10] = 11'(k * 37);
          e = expect_map(m, tb[0], a);
          req(a, 1'b1, e[4:2], e[1:0]);
        end
      end
    end
  endtask

  task automatic offline_and_small;
    wr(4'h0, 32'h0);
    wr(4'h1, 32'h00fac688);
    wr(4'h2, 32'hfe);
    wr(4'h3, 32'h04);
    wr(4'h4, 32'h1);
    req(40'h0110000000, 1'b1, 3'h1, 2'h0);
    req(40'h0013000000, 1'b1, 3'h1, 2'h0);
    req(40'h0130ffffff, 1'b1, 3'h3, 2'h3);
    rd(4'h4, 32'h0);
    req(40'h0131000000, 1'b0, 3'h0, 2'h0);
    rd(4'h4, 32'h00000103);
    rd(4'h5, 32'h00000013);
    req(40'h0000000000, 1'b0, 3'h0, 2'h0);
    wr(4'h4, 32'h1);
    rd(4'h4, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    reset_state();
    mode_sweep();
    offline_and_small();
    test_done();
  end

  // Watchdog: a hung run counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule // imm_mapper_test
